// ### hw/fac_ctrl.sv
// Far-end alarm channel controller: APB registers, codeword transmitter and receiver
`timescale 1ns/100ps

module fac_ctrl (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic slot_en,
    input wire logic rx_bit,
    output logic tx_bit,
    input wire logic channel_master_irq_en,
    output logic irq
);

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [1:0] tx_action_select;
        logic rx_receiver_flush;
        logic [1:0] sel_prev;
        logic flush_prev;
        logic [fac_pkg::NUM_STATUS-1:0] irq_en;
        logic [fac_pkg::CODE_W-1:0] tx_code_a_bits;
        logic [fac_pkg::CODE_W-1:0] tx_code_b_bits;
        logic [fac_pkg::NUM_STATUS-1:0] sticky;
        logic [fac_pkg::NUM_LIVE-1:0] live_prev;
        fac_pkg::fac_tx_state_e tx_state;
        logic [fac_pkg::FRAME_LEN-1:0] tx_frame;
        logic [3:0] tx_bit_idx;
        logic [3:0] tx_rep;
        logic tx_bit;
        logic [fac_pkg::FRAME_LEN-1:0] rx_shift;
        logic [4:0] rx_ones;
        logic [4:0] rx_gap;
        logic [fac_pkg::CODE_W-1:0] rx_cand;
        logic [1:0] rx_cand_cnt;
        logic [fac_pkg::CODE_W-1:0] rx_valid_code;
        logic rx_code_detected_flag;
        logic rx_idle_flag;
        logic [fac_pkg::FIFO_DEPTH-1:0][fac_pkg::CODE_W-1:0] fifo_mem;
        logic [1:0] fifo_wr;
        logic [1:0] fifo_rd;
        logic [2:0] fifo_cnt;
        logic irq;
    } fac_state_s;

    fac_state_s q;
    fac_state_s n;

    logic acc_first;
    logic acc_done;
    logic wr_done;
    logic rd_done;
    logic addr_hit;
    logic [7:0] rd_byte;
    logic [9:0] idx;
    logic start_req;
    logic [fac_pkg::NUM_LIVE-1:0] live;
    logic [fac_pkg::NUM_STATUS-1:0] set_ev;
    logic [fac_pkg::NUM_STATUS-1:0] clr_ev;
    logic [fac_pkg::FRAME_LEN-1:0] rx_sh_n;
    logic rx_match;
    logic [fac_pkg::CODE_W-1:0] rx_code;
    logic [1:0] cnt_n;
    logic push;
    logic pop;
    logic overflow;
    logic [3:0] rep_n;

    // Builds a sixteen-bit frame; bit 0 leaves first, so code bit 0 leaves first
    function automatic logic [fac_pkg::FRAME_LEN-1:0] frame_of(
        input logic [fac_pkg::CODE_W-1:0] code
    );
        frame_of = {1'b0, code, 1'b0, fac_pkg::FLAG_ONES};
    endfunction : frame_of

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        n = q;
        idx = paddr[11:2];
        acc_first = psel & penable & ~q.pready;
        acc_done = psel & penable & q.pready;
        wr_done = acc_done & pwrite;
        rd_done = acc_done & ~pwrite;
        addr_hit = 1'b1;
        rd_byte = 8'h00;
        start_req = 1'b0;
        live = '0;
        set_ev = '0;
        clr_ev = '0;
        rx_sh_n = q.rx_shift;
        rx_match = 1'b0;
        rx_code = '0;
        cnt_n = q.rx_cand_cnt;
        push = 1'b0;
        pop = 1'b0;
        overflow = 1'b0;
        rep_n = q.tx_rep;

        // Read mux; queue data reads zero when the queue is empty
        case (idx)
            fac_pkg::IDX_CONTROL: begin
                rd_byte = {5'h00, q.rx_receiver_flush, q.tx_action_select};
            end
            fac_pkg::IDX_LIVE_STATUS: begin
                rd_byte = {4'h0, q.fifo_cnt == 3'h0, q.rx_idle_flag,
                           q.rx_code_detected_flag, q.tx_state == fac_pkg::TX_IDLE};
            end
            fac_pkg::IDX_STICKY_STATUS: begin
                rd_byte = {3'h0, q.sticky};
            end
            fac_pkg::IDX_IRQ_ENABLE: begin
                rd_byte = {3'h0, q.irq_en};
            end
            fac_pkg::IDX_TX_CODE_A: begin
                rd_byte = {2'h0, q.tx_code_a_bits};
            end
            fac_pkg::IDX_TX_CODE_B: begin
                rd_byte = {2'h0, q.tx_code_b_bits};
            end
            fac_pkg::IDX_RX_FIFO_DATA: begin
                rd_byte = (q.fifo_cnt == 3'h0) ? 8'h00 : {2'h0, q.fifo_mem[q.fifo_rd]};
            end
            default: begin
                addr_hit = 1'b0;
            end
        endcase

        // One wait state: pready rises in the second access cycle
        n.pready = acc_first;
        n.pslverr = acc_first & ~addr_hit;
        if (acc_first) begin
            n.prdata = {24'h000000, rd_byte};
        end

        // Register writes take effect on the completing edge only
        if (wr_done) begin
            case (idx)
                fac_pkg::IDX_CONTROL: begin
                    n.tx_action_select = pwdata[fac_pkg::SEL_MSB:fac_pkg::SEL_LSB];
                    n.rx_receiver_flush = pwdata[fac_pkg::FLUSH_BIT];
                end
                fac_pkg::IDX_STICKY_STATUS: begin
                    clr_ev = pwdata[fac_pkg::NUM_STATUS-1:0];
                end
                fac_pkg::IDX_IRQ_ENABLE: begin
                    n.irq_en = pwdata[fac_pkg::NUM_STATUS-1:0];
                end
                fac_pkg::IDX_TX_CODE_A: begin
                    n.tx_code_a_bits = pwdata[fac_pkg::CODE_W-1:0];
                end
                fac_pkg::IDX_TX_CODE_B: begin
                    n.tx_code_b_bits = pwdata[fac_pkg::CODE_W-1:0];
                end
                default: begin
                end
            endcase
        end
        pop = rd_done && (idx == fac_pkg::IDX_RX_FIFO_DATA) && (q.fifo_cnt != 3'h0);

        ////////////////////////////////////////////////////////////////////////
        // Transmitter; the select field is edge-triggered out of 00
        n.sel_prev = q.tx_action_select;
        start_req = (q.sel_prev == fac_pkg::SEL_IDLE) &&
                    (q.tx_action_select != fac_pkg::SEL_IDLE);
        if (slot_en) begin
            if (q.tx_state == fac_pkg::TX_IDLE) begin
                n.tx_bit = 1'b1;
            end else begin
                // Closing zero is forced, since frame bit 15 doubles as the A-then-B mark
                n.tx_bit = (q.tx_bit_idx == fac_pkg::LAST_BIT) ? 1'b0
                           : q.tx_frame[q.tx_bit_idx];
                n.tx_bit_idx = q.tx_bit_idx + 4'h1;
                if (q.tx_bit_idx == fac_pkg::LAST_BIT) begin
                    // Count saturates so a long continuous run never wraps
                    rep_n = (q.tx_rep == fac_pkg::CODE_REPEAT) ? q.tx_rep : q.tx_rep + 4'h1;
                    n.tx_rep = rep_n;
                    case (q.tx_state)
                        fac_pkg::TX_SEND_A: begin
                            if (rep_n == fac_pkg::CODE_REPEAT) begin
                                // Select is not looked at, so a write of 00 cannot cut it short;
                                // a two-phase run is moved on to codeword B further down
                                n.tx_state = fac_pkg::TX_IDLE;
                            end
                        end
                        fac_pkg::TX_SEND_B: begin
                            if (rep_n == fac_pkg::CODE_REPEAT) begin
                                n.tx_state = fac_pkg::TX_IDLE;
                            end
                        end
                        fac_pkg::TX_CONT: begin
                            n.tx_frame = frame_of(q.tx_code_a_bits);
                            if (rep_n == fac_pkg::CODE_REPEAT &&
                                q.tx_action_select == fac_pkg::SEL_IDLE) begin
                                n.tx_state = fac_pkg::TX_IDLE;
                            end
                        end
                        default: begin
                            n.tx_state = fac_pkg::TX_IDLE;
                        end
                    endcase
                end
            end
        end
        // Two-phase action switches to codeword B after ten copies of A
        if (slot_en && q.tx_state == fac_pkg::TX_SEND_A && q.tx_bit_idx == fac_pkg::LAST_BIT &&
            rep_n == fac_pkg::CODE_REPEAT && q.tx_frame[fac_pkg::FRAME_LEN-1] == 1'b1) begin
            n.tx_state = fac_pkg::TX_SEND_B;
            n.tx_rep = 4'h0;
            n.tx_frame = frame_of(q.tx_code_b_bits);
        end
        // Starts are honoured only from idle; a request while busy is lost
        if (q.tx_state == fac_pkg::TX_IDLE && start_req) begin
            n.tx_bit_idx = 4'h0;
            n.tx_rep = 4'h0;
            // Bit 15 of the frame is always zero on the line; it marks the A-then-B run
            n.tx_frame = frame_of(q.tx_code_a_bits);
            case (q.tx_action_select)
                fac_pkg::SEL_A_ONLY: begin
                    n.tx_state = fac_pkg::TX_SEND_A;
                end
                fac_pkg::SEL_A_THEN_B: begin
                    n.tx_state = fac_pkg::TX_SEND_A;
                    n.tx_frame[fac_pkg::FRAME_LEN-1] = 1'b1;
                end
                default: begin
                    n.tx_state = fac_pkg::TX_CONT;
                end
            endcase
        end

        ////////////////////////////////////////////////////////////////////////
        // Receiver: bit-by-bit search for the codeword pattern
        if (slot_en) begin
            rx_sh_n = {rx_bit, q.rx_shift[fac_pkg::FRAME_LEN-1:1]};
            n.rx_shift = rx_sh_n;
            n.rx_ones = rx_bit ? ((q.rx_ones == fac_pkg::IDLE_ONES) ? q.rx_ones
                                  : q.rx_ones + 5'h01) : 5'h00;
            if (n.rx_ones == fac_pkg::IDLE_ONES) begin
                n.rx_idle_flag = 1'b1;
            end
            rx_match = (rx_sh_n[7:0] == fac_pkg::FLAG_ONES) && !rx_sh_n[8] &&
                       !rx_sh_n[fac_pkg::FRAME_LEN-1];
            rx_code = rx_sh_n[14:9];
            n.rx_gap = (q.rx_gap == 5'h1f) ? q.rx_gap : q.rx_gap + 5'h01;
            if (rx_match) begin
                n.rx_gap = 5'h00;
                // Consecutive means the same code exactly one frame later
                if (q.rx_gap == fac_pkg::GAP_ONE_FRAME && rx_code == q.rx_cand) begin
                    cnt_n = (q.rx_cand_cnt == fac_pkg::VALID_COUNT) ? q.rx_cand_cnt
                            : q.rx_cand_cnt + 2'h1;
                end else begin
                    cnt_n = 2'h1;
                end
                n.rx_cand = rx_code;
                n.rx_cand_cnt = cnt_n;
                if (cnt_n == fac_pkg::VALID_COUNT && q.rx_cand_cnt != fac_pkg::VALID_COUNT &&
                    !(q.rx_code_detected_flag && rx_code == q.rx_valid_code)) begin
                    n.rx_code_detected_flag = 1'b1;
                    n.rx_valid_code = rx_code;
                    n.rx_idle_flag = 1'b0;
                    push = 1'b1;
                end
                // A different code seen twice in a row ends the detection
                if (cnt_n == fac_pkg::LOSS_COUNT && q.rx_code_detected_flag &&
                    rx_code != q.rx_valid_code) begin
                    n.rx_code_detected_flag = 1'b0;
                end
            end
        end

        // Receive queue, four entries; a push into a full queue is dropped unless a pop comes in the same cycle
        overflow = push && (q.fifo_cnt == fac_pkg::FIFO_FULL) && !pop;
        if (push && !overflow) begin
            n.fifo_mem[q.fifo_wr] = rx_code;
            n.fifo_wr = q.fifo_wr + 2'h1;
        end
        if (pop) begin
            n.fifo_rd = q.fifo_rd + 2'h1;
        end
        n.fifo_cnt = q.fifo_cnt + {2'h0, push && !overflow} - {2'h0, pop};

        // Flush on a rising control bit wins over any push or pop
        n.flush_prev = q.rx_receiver_flush;
        if (q.rx_receiver_flush && !q.flush_prev) begin
            n.rx_shift = '0;
            n.rx_ones = 5'h00;
            n.rx_gap = 5'h00;
            n.rx_cand = '0;
            n.rx_cand_cnt = 2'h0;
            n.rx_valid_code = '0;
            n.rx_code_detected_flag = 1'b0;
            n.rx_idle_flag = 1'b0;
            n.fifo_wr = 2'h0;
            n.fifo_rd = 2'h0;
            n.fifo_cnt = 3'h0;
            overflow = 1'b0;
        end

        ////////////////////////////////////////////////////////////////////////
        // Sticky bits: edges of the live flags, plus queue overflow; a new event beats a clear
        live[fac_pkg::TX_IDLE_BIT] = (q.tx_state == fac_pkg::TX_IDLE);
        live[fac_pkg::RX_DET_BIT] = q.rx_code_detected_flag;
        live[fac_pkg::RX_IDLE_BIT] = q.rx_idle_flag;
        live[fac_pkg::RX_QUEUE_BIT] = (q.fifo_cnt == 3'h0);
        n.live_prev = live;
        set_ev[fac_pkg::RX_IDLE_BIT:0] = live[fac_pkg::RX_IDLE_BIT:0] &
                                         ~q.live_prev[fac_pkg::RX_IDLE_BIT:0];
        set_ev[fac_pkg::RX_QUEUE_BIT] = !live[fac_pkg::RX_QUEUE_BIT] &&
                                        q.live_prev[fac_pkg::RX_QUEUE_BIT];
        set_ev[fac_pkg::RX_OVF_BIT] = overflow;
        n.sticky = (q.sticky & ~clr_ev) | set_ev;

        // Interrupt level, gated per source and by the channel master enable
        n.irq = channel_master_irq_en && |(q.sticky & q.irq_en);
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '0;
            q.tx_bit <= 1'b1;
            q.live_prev <= 4'h9;
        end else begin
            q <= n;
        end
    end

    // Outputs straight from flip-flops
    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign tx_bit = q.tx_bit;
    assign irq = q.irq;

endmodule : fac_ctrl

// ### hw/fac_pkg.sv
// Package: register map, field positions, counts and states of the alarm channel controller
package fac_pkg;

    // Register indices; the byte address on the bus is four times the index
    localparam logic [9:0] IDX_CONTROL = 10'h060;
    localparam logic [9:0] IDX_LIVE_STATUS = 10'h061;
    localparam logic [9:0] IDX_STICKY_STATUS = 10'h062;
    localparam logic [9:0] IDX_IRQ_ENABLE = 10'h063;
    localparam logic [9:0] IDX_TX_CODE_A = 10'h064;
    localparam logic [9:0] IDX_TX_CODE_B = 10'h065;
    localparam logic [9:0] IDX_RX_FIFO_DATA = 10'h066;

    // Control register fields
    localparam int SEL_LSB = 0;
    localparam int SEL_MSB = 1;
    localparam int FLUSH_BIT = 2;

    // Status bit positions, shared by live, sticky and enable registers
    localparam int TX_IDLE_BIT = 0;
    localparam int RX_DET_BIT = 1;
    localparam int RX_IDLE_BIT = 2;
    localparam int RX_QUEUE_BIT = 3;
    localparam int RX_OVF_BIT = 4;
    localparam int NUM_STATUS = 5;
    localparam int NUM_LIVE = 4;

    // Widths
    localparam int CODE_W = 6;
    localparam int FRAME_LEN = 16;
    localparam int FIFO_DEPTH = 4;

    // Action select encodings
    localparam logic [1:0] SEL_IDLE = 2'h0;
    localparam logic [1:0] SEL_A_ONLY = 2'h1;
    localparam logic [1:0] SEL_A_THEN_B = 2'h2;
    localparam logic [1:0] SEL_A_CONT = 2'h3;

    // Counts
    localparam logic [3:0] CODE_REPEAT = 4'ha;
    localparam logic [3:0] LAST_BIT = 4'hf;
    localparam logic [1:0] VALID_COUNT = 2'h3;
    localparam logic [1:0] LOSS_COUNT = 2'h2;
    localparam logic [4:0] IDLE_ONES = 5'h10;
    localparam logic [4:0] GAP_ONE_FRAME = 5'h0f;
    localparam logic [2:0] FIFO_FULL = 3'h4;

    // Frame pattern pieces: eight ones go first, then a zero, six code bits, a zero
    localparam logic [7:0] FLAG_ONES = 8'hff;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_SEND_A = 2'b01,
        TX_SEND_B = 2'b10,
        TX_CONT = 2'b11
    } fac_tx_state_e;

endpackage : fac_pkg

// ### sim/fac_ctrl_checker.sv
// Checker: port-level properties of the alarm channel controller
`timescale 1ns/100ps
module fac_ctrl_checker (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic slot_en,
    input wire logic rx_bit,
    input wire logic tx_bit,
    input wire logic channel_master_irq_en,
    input wire logic irq
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    logic done;
    logic mapped;
    logic started_q;
    logic [3:0] zrun_q;
    ////////////////////////////////////////////////////////////////
    // Completed transfer, and whether it hit a mapped word
    assign done = psel && penable && pready;
    assign mapped = paddr[11:2] >= fac_pkg::IDX_CONTROL
        && paddr[11:2] <= fac_pkg::IDX_RX_FIFO_DATA;
    // Start seen yet, and zero run on the line; a frame never holds more than eight zeros
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            started_q <= 1'b0;
            zrun_q <= 4'h0;
        end else begin
            if (done && pwrite && paddr[11:2] == fac_pkg::IDX_CONTROL && pwdata[1:0] != 2'h0) begin
                started_q <= 1'b1;
            end
            if (slot_en) begin
                zrun_q <= tx_bit ? 4'h0 : zrun_q + 4'h1;
            end
        end
    end
    ////////////////////////////////////////////////////////////////
    one_wait_a: assert property ($rose(penable) && psel |=> pready)
        else $error("pready missing after first access cycle");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready stood longer than one cycle");
    unmapped_err_a: assert property (done && !mapped |-> pslverr)
        else $error("unmapped access without error");
    mapped_ok_a: assert property (done && mapped |-> !pslverr)
        else $error("mapped access flagged as error");
    code_width_a: assert property (done && !pwrite && paddr[11:2] == fac_pkg::IDX_RX_FIFO_DATA
        |-> prdata[31:6] == 26'h0) else $error("queue data wider than six bits");
    idle_ones_a: assert property (!started_q |-> tx_bit)
        else $error("line left ones without a start");
    slot_hold_a: assert property (!slot_en |=> $stable(tx_bit))
        else $error("line bit changed outside a slot");
    frame_zeros_a: assert property (zrun_q <= 4'h8)
        else $error("too many zeros in a row on the line");
    irq_master_a: assert property (!channel_master_irq_en |=> !irq)
        else $error("interrupt with master enable low");
    irq_cause_a: assert property ($rose(irq) |-> $past(channel_master_irq_en))
        else $error("interrupt rose without master enable");
    cover property ($rose(irq));
    cover property (done && pslverr);
    cover property ($fell(tx_bit));
endmodule : fac_ctrl_checker

bind fac_ctrl fac_ctrl_checker u_chk (.clock(clock), .sys_rst(sys_rst), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .slot_en(slot_en), .rx_bit(rx_bit),
    .tx_bit(tx_bit), .channel_master_irq_en(channel_master_irq_en), .irq(irq));

// ### sim/fac_far_end.sv
// Far-end model: overhead slot strobe, remote loopback of the line, frame counter
`timescale 1ns/100ps
module fac_far_end (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic tx_bit,
    output logic slot_en,
    output logic rx_bit,
    output logic [7:0] frames
);
    logic [1:0] gap_q;
    logic [3:0] ones_q;
    ////////////////////////////////////////////////////////////////
    // One slot every four clocks; the remote end echoes each bit one slot late,
    // so our receiver sees exactly what we sent. A zero after eight ones opens a frame.
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            gap_q <= 2'h0;
            ones_q <= 4'h0;
            slot_en <= 1'b0;
            rx_bit <= 1'b1;
            frames <= 8'h0;
        end else begin
            gap_q <= gap_q + 2'h1;
            slot_en <= (gap_q == 2'h0);
            if (slot_en) begin
                rx_bit <= tx_bit;
                ones_q <= tx_bit ? ((ones_q == 4'hf) ? ones_q : ones_q + 4'h1) : 4'h0;
                if (!tx_bit && ones_q >= 4'h8) begin
                    frames <= frames + 8'h1;
                end
            end
        end
    end
endmodule : fac_far_end

// ### sim/test_far_end_alarm_channel_ctrl.sv
// Testbench: scenario tasks for the alarm channel controller
`timescale 1ns/100ps
module test_far_end_alarm_channel_ctrl;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic [11:0] paddr = 12'h0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic master_en = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic slot_en;
    logic rx_bit;
    logic tx_bit;
    logic irq;
    logic [7:0] frames;
    logic [31:0] rd;
    logic err;
    int n_errors = 0;
    int checks_done = 0;
    ////////////////////////////////////////////////////////////////
    fac_ctrl DUT (.clock(clock), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .slot_en(slot_en), .rx_bit(rx_bit), .tx_bit(tx_bit),
        .channel_master_irq_en(master_en), .irq(irq));
    fac_far_end u_far (.clock(clock), .sys_rst(sys_rst), .tx_bit(tx_bit), .slot_en(slot_en),
        .rx_bit(rx_bit), .frames(frames));
    // 125 MHz clock
    initial begin
        forever #4 clock = ~clock;
    end
    ////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : print_verdict
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // One APB transfer; holds the request until pready is sampled, bounded wait
    task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            check(32'h0, 32'h1);
            print_verdict();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdchk(input logic [9:0] idx, input logic [7:0] m, input logic [7:0] e);
        apb(1'b0, idx, 8'h0);
        check(rd & {24'h0, m}, {24'h0, e});
    endtask : rdchk
    // Polls the live transmit idle bit; polling keeps us off any assumed duration
    task automatic wait_idle();
        int n;
        for (n = 0; n < 4000; n++) begin
            apb(1'b0, fac_pkg::IDX_LIVE_STATUS, 8'h0);
            if (rd[fac_pkg::TX_IDLE_BIT] === 1'b1) break;
        end
        if (n == 4000) begin
            check(32'h0, 32'h1);
            print_verdict();
        end
    endtask : wait_idle
    task automatic start(input logic [1:0] sel);
        apb(1'b1, fac_pkg::IDX_CONTROL, 8'h00);
        apb(1'b1, fac_pkg::IDX_CONTROL, {6'h0, sel});
    endtask : start
    // Interrupt output is registered: one edge to land, one to sample
    task automatic irq_is(input logic e);
        repeat (2) @(posedge clock);
        check({31'h0, irq}, {31'h0, e});
    endtask : irq_is
    ////////////////////////////////////////////////////////////////
    task automatic t_regs();
        rdchk(fac_pkg::IDX_CONTROL, 8'hff, 8'h00);
        rdchk(fac_pkg::IDX_IRQ_ENABLE, 8'hff, 8'h00);
        rdchk(fac_pkg::IDX_LIVE_STATUS, 8'h09, 8'h09);
        apb(1'b1, fac_pkg::IDX_TX_CODE_B, 8'hff);
        rdchk(fac_pkg::IDX_TX_CODE_B, 8'hff, 8'h3f);
        apb(1'b1, 10'h067, 8'h5a);
        check({31'h0, err}, 32'h1);
        rdchk(10'h067, 8'hff, 8'h00);
        check({31'h0, err}, 32'h1);
        $display("test regs done");
    endtask : t_regs
    task automatic t_single();
        logic [7:0] f0;
        apb(1'b1, fac_pkg::IDX_TX_CODE_A, 8'h15);
        f0 = frames;
        start(fac_pkg::SEL_A_ONLY);
        apb(1'b1, fac_pkg::IDX_CONTROL, 8'h00);
        rdchk(fac_pkg::IDX_LIVE_STATUS, 8'h01, 8'h00);
        wait_idle();
        // Sixteen idle slots of four clocks, plus the loopback slot
        repeat (100) @(posedge clock);
        check({24'h0, frames - f0}, 32'ha);
        rdchk(fac_pkg::IDX_LIVE_STATUS, 8'h0f, 8'h07);
        rdchk(fac_pkg::IDX_STICKY_STATUS, 8'h1b, 8'h0b);
        rdchk(fac_pkg::IDX_RX_FIFO_DATA, 8'hff, 8'h15);
        rdchk(fac_pkg::IDX_LIVE_STATUS, 8'h08, 8'h08);
        $display("test single done");
    endtask : t_single
    task automatic t_irq();
        logic [7:0] s;
        int b;
        apb(1'b0, fac_pkg::IDX_STICKY_STATUS, 8'h0);
        s = 8'h0f;
        check(rd, {24'h0, s});
        master_en <= 1'b1;
        for (b = 0; b < 5; b++) begin
            apb(1'b1, fac_pkg::IDX_IRQ_ENABLE, 8'(8'h01 << b));
            irq_is(s[b]);
        end
        apb(1'b1, fac_pkg::IDX_IRQ_ENABLE, 8'h08);
        master_en <= 1'b0;
        irq_is(1'b0);
        master_en <= 1'b1;
        irq_is(1'b1);
        apb(1'b1, fac_pkg::IDX_STICKY_STATUS, 8'h1f);
        irq_is(1'b0);
        rdchk(fac_pkg::IDX_STICKY_STATUS, 8'h1f, 8'h00);
        apb(1'b1, fac_pkg::IDX_IRQ_ENABLE, 8'h1f);
        irq_is(1'b0);
        $display("test irq done");
    endtask : t_irq
    task automatic t_ab();
        logic [7:0] f0;
        apb(1'b1, fac_pkg::IDX_TX_CODE_A, 8'h2a);
        apb(1'b1, fac_pkg::IDX_TX_CODE_B, 8'h33);
        f0 = frames;
        start(fac_pkg::SEL_A_THEN_B);
        apb(1'b1, fac_pkg::IDX_CONTROL, 8'h00);
        wait_idle();
        check({24'h0, frames - f0}, 32'h14);
        rdchk(fac_pkg::IDX_RX_FIFO_DATA, 8'hff, 8'h2a);
        rdchk(fac_pkg::IDX_RX_FIFO_DATA, 8'hff, 8'h33);
        rdchk(fac_pkg::IDX_LIVE_STATUS, 8'h08, 8'h08);
        $display("test a then b done");
    endtask : t_ab
    task automatic t_cont();
        logic [7:0] f0;
        int n;
        apb(1'b1, fac_pkg::IDX_TX_CODE_A, 8'h0c);
        f0 = frames;
        start(fac_pkg::SEL_A_CONT);
        for (n = 0; n < 2000 && frames - f0 < 8'h3; n++) begin
            @(posedge clock);
        end
        if (n == 2000) begin
            check(32'h0, 32'h1);
            print_verdict();
        end
        apb(1'b1, fac_pkg::IDX_CONTROL, 8'h00);
        wait_idle();
        check({24'h0, frames - f0}, 32'ha);
        rdchk(fac_pkg::IDX_RX_FIFO_DATA, 8'hff, 8'h0c);
        $display("test continuous done");
    endtask : t_cont
    task automatic t_ovf();
        int b;
        for (b = 1; b < 6; b++) begin
            apb(1'b1, fac_pkg::IDX_TX_CODE_A, 8'(b));
            start(fac_pkg::SEL_A_ONLY);
            wait_idle();
        end
        rdchk(fac_pkg::IDX_STICKY_STATUS, 8'h10, 8'h10);
        rdchk(fac_pkg::IDX_RX_FIFO_DATA, 8'hff, 8'h01);
        apb(1'b1, fac_pkg::IDX_CONTROL, 8'h04);
        rdchk(fac_pkg::IDX_LIVE_STATUS, 8'h0e, 8'h08);
        rdchk(fac_pkg::IDX_RX_FIFO_DATA, 8'hff, 8'h00);
        apb(1'b1, fac_pkg::IDX_CONTROL, 8'h00);
        apb(1'b1, fac_pkg::IDX_STICKY_STATUS, 8'h10);
        rdchk(fac_pkg::IDX_STICKY_STATUS, 8'h10, 8'h00);
        $display("test overflow done");
    endtask : t_ovf
    ////////////////////////////////////////////////////////////////
    // Main sequence: reset for four cycles, then every scenario in turn
    initial begin
        repeat (4) @(posedge clock);
        sys_rst <= 1'b0;
        t_regs();
        t_single();
        t_irq();
        t_ab();
        t_cont();
        t_ovf();
        print_verdict();
    end
endmodule : test_far_end_alarm_channel_ctrl
